/* src/scm_bclk_div.sv */
// Bus clock divider that switches source and ratio only at period boundaries or while held low.
// Assumes source edge pulses already synchronised to hclk.
`timescale 1ns/10ps
`default_nettype none
module scm_bclk_div (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       clk_en,
	input  wire logic [1:0] src_edge,
	input  wire logic       src_sel,
	input  wire logic [4:0] half_ratio,
	input  wire logic       hold,
	output logic            bclk
);
	logic       out_reg;
	logic       out_next;
	logic       sel_reg;
	logic       sel_next;
	logic [4:0] ratio_reg;
	logic [4:0] ratio_next;
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;

	always_comb begin
		out_next = out_reg;
		sel_next = sel_reg;
		ratio_next = ratio_reg;
		cnt_next = cnt_reg;
		if (!out_reg && hold) begin
			// Parked low; new settings only lengthen the low phase.
			sel_next = src_sel;
			ratio_next = half_ratio;
			cnt_next = 5'h00;
		end else if (src_edge[sel_reg]) begin
			if (cnt_reg == ratio_reg - 5'h01) begin
				out_next = !out_reg;
				cnt_next = 5'h00;
				if (out_reg) begin
					sel_next = src_sel;
					ratio_next = half_ratio;
				end
			end else begin
				cnt_next = cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_reg <= 1'b0;
			sel_reg <= 1'b0;
			ratio_reg <= scm_pkg::HALF_8;
			cnt_reg <= 5'h00;
		end else if (clk_en) begin
			out_reg <= out_next;
			sel_reg <= sel_next;
			ratio_reg <= ratio_next;
			cnt_reg <= cnt_next;
		end
	end

	assign bclk = out_reg;
endmodule
`default_nettype wire

/* src/scm_clock_ctrl.sv */
// System clock mode control with oscillator stop detection, AHB-Lite slave.
// Assumes oscillator pins are asynchronous to hclk and much slower than it.
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module scm_clock_ctrl (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 clk_en,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 main_osc_input,
	input  wire logic                 sub_osc_input,
	input  wire logic                 ring_osc_input,
	input  wire logic                 wait_req,
	input  wire logic                 wake_req,
	output logic                      cpu_bus_clk,
	output logic                      cpu_halt,
	output logic                      periph_clk_en,
	output logic                      sub_periph_clk_en,
	output scm_pkg::scm_osc_en_t      osc_en,
	output logic                      osc_stop_irq
);
	logic [2:0]           pin_s1_reg;
	logic [2:0]           pin_s2_reg;
	logic [2:0]           pin_s3_reg;
	logic [2:0]           pin_edge;
	logic                 main_edge;
	logic                 sub_edge;
	logic                 ring_edge;
	logic                 ph_valid_reg;
	logic                 ph_valid_next;
	logic                 ph_write_reg;
	logic                 ph_write_next;
	logic [5:0]           ph_idx_reg;
	logic [5:0]           ph_idx_next;
	logic [31:0]          rdata_reg;
	logic [31:0]          rdata_next;
	scm_pkg::scm_ctrl_t   ctrl_reg;
	scm_pkg::scm_ctrl_t   ctrl_next;
	scm_pkg::scm_pstate_t ps_reg;
	scm_pkg::scm_pstate_t ps_next;
	logic                 prot_reg;
	logic                 prot_next;
	logic [7:0]           det_cnt_reg;
	logic [7:0]           det_cnt_next;
	logic                 irq_reg;
	logic                 irq_next;
	scm_pkg::scm_osc_en_t osc_reg;
	scm_pkg::scm_osc_en_t osc_next;
	logic                 periph_reg;
	logic                 periph_next;
	logic                 sub_periph_reg;
	logic                 sub_periph_next;
	logic                 halt_reg;
	logic                 halt_next;
	logic                 low_speed;
	logic                 low_power_next;
	logic                 det_armed;
	logic                 det_forced;
	logic                 det_fire;
	logic                 stopping;
	logic                 wait_gated;
	logic                 main_clk_edge;
	logic [4:0]           half_ratio;

	// Write strobe for one register during a write data phase.
	function automatic logic reg_write(
		input logic       valid,
		input logic       write,
		input logic [5:0] idx,
		input logic [5:0] target
	);
		return valid && write && (idx == target);
	endfunction

	// Read image of one register; unmapped words read as zero.
	function automatic logic [31:0] read_word(
		input logic [5:0]         idx,
		input scm_pkg::scm_ctrl_t c,
		input logic               prot,
		input logic               in_stop
	);
		logic [31:0] w;
		w = scm_pkg::RD_ZERO;
		case (idx)
			scm_pkg::IDX_CTRL0: begin
				w[scm_pkg::B_WPS] = c.wait_periph_clock_stop;
				w[scm_pkg::B_SUBP] = c.sub_osc_port_select;
				w[scm_pkg::B_MSTOP] = c.main_clock_stop_bit;
				w[scm_pkg::B_DIV8] = c.main_divide_by_eight_select;
				w[scm_pkg::B_SYSSRC] = c.system_clock_source_select;
			end
			scm_pkg::IDX_CTRL1: begin
				w[scm_pkg::B_STOPALL] = in_stop;
				w[scm_pkg::B_RSTOP] = c.ring_osc_stop_bit;
				w[scm_pkg::B_DIVLO] = c.main_divider_field_low;
				w[scm_pkg::B_DIVHI] = c.main_divider_field_high;
			end
			scm_pkg::IDX_PROT: begin
				w[scm_pkg::B_PROT] = prot;
			end
			scm_pkg::IDX_OSD: begin
				w[scm_pkg::B_DETEN] = c.osc_stop_detect_enable;
				w[scm_pkg::B_IRQEN] = c.osc_stop_irq_enable;
				w[scm_pkg::B_RSEL] = c.ring_source_select;
				w[scm_pkg::B_MON] = c.main_osc_monitor_bit & c.osc_stop_detect_enable;
			end
			default: begin
				w = scm_pkg::RD_ZERO;
			end
		endcase
		return w;
	endfunction

	// Oscillator pins: two stages, then a third stage for edge detection.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
			pin_s3_reg <= 3'h0;
		end else if (clk_en) begin
			pin_s1_reg <= {ring_osc_input, sub_osc_input, main_osc_input};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign pin_edge = pin_s2_reg ^ pin_s3_reg;
	assign main_edge = pin_edge[0];
	assign sub_edge = pin_edge[1];
	assign ring_edge = pin_edge[2];

	// Bus address phase capture and read data.
	always_comb begin
		ph_valid_next = hsel && htrans[scm_pkg::HTRANS_ACT] && hready;
		ph_write_next = hwrite;
		ph_idx_next = haddr[scm_pkg::IDX_MSB:scm_pkg::IDX_LSB];
		rdata_next = rdata_reg;
		if (ph_valid_next && !hwrite) begin
			// Next values make a read right after a write see that write.
			rdata_next = read_word(ph_idx_next, ctrl_next, prot_next, ps_next == scm_pkg::PS_STOP);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_reg <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_idx_reg <= 6'h00;
			rdata_reg <= scm_pkg::RD_ZERO;
		end else if (clk_en) begin
			ph_valid_reg <= ph_valid_next;
			ph_write_reg <= ph_write_next;
			ph_idx_reg <= ph_idx_next;
			rdata_reg <= rdata_next;
		end
	end

	assign low_speed = !ctrl_reg.ring_source_select
		&& ctrl_reg.system_clock_source_select
		&& ctrl_reg.sub_osc_port_select;
	assign det_armed = ctrl_reg.osc_stop_detect_enable && ctrl_reg.osc_stop_irq_enable;
	assign det_forced = (ps_reg == scm_pkg::PS_WAIT) && ctrl_reg.wait_periph_clock_stop;
	assign det_fire = det_armed && ((det_cnt_reg == scm_pkg::DET_LIMIT) || det_forced);

	// Control registers, power state, stop detection and output enables.
	always_comb begin
		ctrl_next = ctrl_reg;
		ps_next = ps_reg;
		prot_next = prot_reg;
		irq_next = 1'b0;
		det_cnt_next = det_cnt_reg;
		if (reg_write(ph_valid_reg, ph_write_reg, ph_idx_reg, scm_pkg::IDX_PROT)) begin
			prot_next = hwdata[scm_pkg::B_PROT];
		end
		if (prot_reg && reg_write(ph_valid_reg, ph_write_reg, ph_idx_reg, scm_pkg::IDX_CTRL0)) begin
			ctrl_next.wait_periph_clock_stop = hwdata[scm_pkg::B_WPS];
			ctrl_next.sub_osc_port_select = hwdata[scm_pkg::B_SUBP];
			ctrl_next.main_clock_stop_bit = hwdata[scm_pkg::B_MSTOP];
			ctrl_next.main_divide_by_eight_select = hwdata[scm_pkg::B_DIV8];
			// The sub clock becomes the source only once its port is already selected.
			ctrl_next.system_clock_source_select = hwdata[scm_pkg::B_SYSSRC]
				&& ctrl_reg.sub_osc_port_select;
		end
		if (prot_reg && reg_write(ph_valid_reg, ph_write_reg, ph_idx_reg, scm_pkg::IDX_CTRL1)) begin
			ctrl_next.main_divider_field_low = hwdata[scm_pkg::B_DIVLO];
			ctrl_next.main_divider_field_high = hwdata[scm_pkg::B_DIVHI];
			// The ring oscillator may only be stopped while nothing depends on it.
			ctrl_next.ring_osc_stop_bit = hwdata[scm_pkg::B_RSTOP]
				&& !ctrl_reg.ring_source_select
				&& !ctrl_reg.main_osc_monitor_bit;
			if (hwdata[scm_pkg::B_STOPALL] && ps_reg == scm_pkg::PS_RUN
				&& !ctrl_reg.ring_source_select) begin
				ps_next = scm_pkg::PS_STOP;
				if (!low_speed) begin
					ctrl_next.main_divide_by_eight_select = 1'b1;
				end
			end
		end
		if (prot_reg && reg_write(ph_valid_reg, ph_write_reg, ph_idx_reg, scm_pkg::IDX_OSD)) begin
			ctrl_next.osc_stop_detect_enable = hwdata[scm_pkg::B_DETEN];
			ctrl_next.osc_stop_irq_enable = hwdata[scm_pkg::B_IRQEN];
			// Ring source clears only while the main oscillator is seen running.
			if (hwdata[scm_pkg::B_RSEL] || !ctrl_reg.main_osc_monitor_bit) begin
				ctrl_next.ring_source_select = hwdata[scm_pkg::B_RSEL];
			end
		end
		if (ps_reg == scm_pkg::PS_RUN && wait_req && ps_next == scm_pkg::PS_RUN) begin
			ps_next = scm_pkg::PS_WAIT;
		end else if (ps_reg != scm_pkg::PS_RUN && wake_req) begin
			ps_next = scm_pkg::PS_RUN;
		end
		if (!det_armed || main_edge) begin
			det_cnt_next = 8'h00;
		end else if (det_cnt_reg != scm_pkg::DET_LIMIT) begin
			det_cnt_next = det_cnt_reg + 8'h01;
		end
		if (!ctrl_reg.osc_stop_detect_enable) begin
			ctrl_next.main_osc_monitor_bit = 1'b0;
		end else if (main_edge && !det_forced) begin
			ctrl_next.main_osc_monitor_bit = 1'b0;
		end
		if (det_fire && !ctrl_reg.main_osc_monitor_bit) begin
			ctrl_next.main_osc_monitor_bit = 1'b1;
			ctrl_next.ring_source_select = 1'b1;
			irq_next = 1'b1;
		end
		if (ctrl_next.ring_source_select) begin
			ctrl_next.ring_osc_stop_bit = 1'b0;
		end
		stopping = ps_next == scm_pkg::PS_STOP;
		wait_gated = (ps_next == scm_pkg::PS_WAIT) && ctrl_next.wait_periph_clock_stop;
		low_power_next = !ctrl_next.ring_source_select
			&& ctrl_next.system_clock_source_select
			&& ctrl_next.sub_osc_port_select
			&& ctrl_next.main_clock_stop_bit;
		osc_next.main_en = !ctrl_next.main_clock_stop_bit && !stopping;
		osc_next.sub_en = ctrl_next.sub_osc_port_select && !stopping;
		osc_next.ring_en = !ctrl_next.ring_osc_stop_bit && !stopping;
		halt_next = ps_next != scm_pkg::PS_RUN;
		periph_next = !stopping && !wait_gated && !low_power_next;
		sub_periph_next = osc_next.sub_en && !wait_gated;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= scm_pkg::CTRL_RST;
			ps_reg <= scm_pkg::PS_RUN;
			prot_reg <= 1'b0;
			det_cnt_reg <= 8'h00;
			irq_reg <= 1'b0;
			osc_reg <= scm_pkg::OSC_RST;
			halt_reg <= 1'b0;
			periph_reg <= 1'b1;
			sub_periph_reg <= 1'b0;
		end else if (clk_en) begin
			ctrl_reg <= ctrl_next;
			ps_reg <= ps_next;
			prot_reg <= prot_next;
			det_cnt_reg <= det_cnt_next;
			irq_reg <= irq_next;
			osc_reg <= osc_next;
			halt_reg <= halt_next;
			periph_reg <= periph_next;
			sub_periph_reg <= sub_periph_next;
		end
	end

	// A failed main oscillator is replaced at once; a runt phase is the lesser harm.
	assign main_clk_edge = ctrl_reg.ring_source_select ? ring_edge : main_edge;
	// The sub clock drives the bus undivided; the divide settings steer the main path only.
	assign half_ratio = low_speed ? scm_pkg::HALF_1 : scm_pkg::scm_half_ratio(
		ctrl_reg.main_divide_by_eight_select,
		{ctrl_reg.main_divider_field_high, ctrl_reg.main_divider_field_low});

	scm_bclk_div u_div (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.clk_en     (clk_en),
		.src_edge   ({sub_edge, main_clk_edge}),
		.src_sel    (low_speed),
		.half_ratio (half_ratio),
		.hold       (ps_reg != scm_pkg::PS_RUN),
		.bclk       (cpu_bus_clk)
	);

	assign hreadyout = 1'b1;
	assign hresp = scm_pkg::HRESP_OKAY;
	assign hrdata = rdata_reg;
	assign cpu_halt = halt_reg;
	assign periph_clk_en = periph_reg;
	assign sub_periph_clk_en = sub_periph_reg;
	assign osc_en = osc_reg;
	assign osc_stop_irq = irq_reg;
endmodule
`default_nettype wire

/* src/scm_pkg.sv */
// System clock mode package: register map, field positions, states, types.
// Assumes a 32-bit AHB-Lite bus and one bus clock hclk running at 125 MHz.
// What this block does
// - Field 01 without divide-by-8 runs the bus clock at main clock over 2.
// - Field 10 without divide-by-8 runs the bus clock at main clock over 4.
// - Divide-by-8 select set divides the main clock by 8, field ignored.
// - Field 11 without divide-by-8 runs the bus clock at main clock over 16.
// - Field 00 without divide-by-8 passes the main clock undivided.
// - Source select and sub port select make the sub clock the bus clock while ring source select is clear.
// - Main stop in low-speed mode halts main oscillator; only sub-clocked peripherals run.
// - Ring source select uses the ring oscillator with the same divide choices.
// - Wait mode halts the CPU and bus clock while oscillators keep running.
// - Stop mode stops every oscillator, the CPU and all peripheral clocks.
// - In ring mode the main stop bit may stop the main oscillator.
// - Detection needs both detect and interrupt enable; both reset to zero.
// - A detected main stop raises the interrupt and swaps in the ring oscillator.
// - No detection while detect enable is zero or during reset.
// - Wait mode with peripheral clocks stopped is detected as a main stop.
// - Reset sets the divide-by-8 select.
// - Detection sets ring source select; that select clears ring stop.
// - Monitor bit reads 0 while main runs outside a forced wait detection, and while detection is off.
// - Register write-enable bit stays set until software clears it or reset clears it.
package scm_pkg;
	localparam logic [5:0]  IDX_CTRL0 = 6'h06;
	localparam logic [5:0]  IDX_CTRL1 = 6'h07;
	localparam logic [5:0]  IDX_PROT  = 6'h0A;
	localparam logic [5:0]  IDX_OSD   = 6'h0C;
	localparam int          IDX_LSB   = 2;
	localparam int          IDX_MSB   = 7;
	localparam int          HTRANS_ACT = 1;
	localparam int          B_WPS     = 2;
	localparam int          B_SUBP    = 4;
	localparam int          B_MSTOP   = 5;
	localparam int          B_DIV8    = 6;
	localparam int          B_SYSSRC  = 7;
	localparam int          B_STOPALL = 0;
	localparam int          B_RSTOP   = 4;
	localparam int          B_DIVLO   = 6;
	localparam int          B_DIVHI   = 7;
	localparam int          B_DETEN   = 0;
	localparam int          B_IRQEN   = 1;
	localparam int          B_RSEL    = 2;
	localparam int          B_MON     = 3;
	localparam int          B_PROT    = 0;
	localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
	localparam logic        HRESP_OKAY = 1'b0;
	localparam int          HCLK_MHZ  = 125;
	localparam int          DET_TIMEOUT_NS = 1000;
	localparam int          DET_CYCLES = (DET_TIMEOUT_NS * HCLK_MHZ + 999) / 1000;
	localparam logic [7:0]  DET_LIMIT = 8'(DET_CYCLES);
	localparam logic [4:0]  HALF_1    = 5'h01;
	localparam logic [4:0]  HALF_2    = 5'h02;
	localparam logic [4:0]  HALF_4    = 5'h04;
	localparam logic [4:0]  HALF_8    = 5'h08;
	localparam logic [4:0]  HALF_16   = 5'h10;

	typedef enum logic [1:0] {
		PS_RUN  = 2'b00,
		PS_WAIT = 2'b01,
		PS_STOP = 2'b10
	} scm_pstate_t;

	typedef struct packed {
		logic ring_source_select;
		logic main_divider_field_high;
		logic main_divider_field_low;
		logic system_clock_source_select;
		logic main_divide_by_eight_select;
		logic main_clock_stop_bit;
		logic sub_osc_port_select;
		logic wait_periph_clock_stop;
		logic ring_osc_stop_bit;
		logic osc_stop_detect_enable;
		logic osc_stop_irq_enable;
		logic main_osc_monitor_bit;
	} scm_ctrl_t;

	typedef struct packed {
		logic main_en;
		logic sub_en;
		logic ring_en;
	} scm_osc_en_t;

	localparam scm_ctrl_t CTRL_RST = '{main_divide_by_eight_select: 1'b1, default: 1'b0};
	localparam scm_osc_en_t OSC_RST = '{main_en: 1'b1, sub_en: 1'b0, ring_en: 1'b1};

	// Source edges counted per half period of the bus clock.
	function automatic logic [4:0] scm_half_ratio(input logic div8, input logic [1:0] field);
		logic [4:0] r;
		r = HALF_8;
		if (!div8) begin
			case (field)
				2'h0: r = HALF_1;
				2'h1: r = HALF_2;
				2'h2: r = HALF_4;
				2'h3: r = HALF_16;
				default: r = HALF_8;
			endcase
		end
		return r;
	endfunction
endpackage

/* testbench/scm_clock_ctrl_assertions.sv */
// Concurrent checks on power state, oscillator enables and stop detection.
// Assumes one clock hclk and an asynchronous active-low reset hresetn.
`timescale 1ns/10ps
`default_nettype none
module scm_clock_ctrl_assertions (
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic                 clk_en,
	input wire logic                 main_osc_input,
	input wire logic                 wait_req,
	input wire logic                 wake_req,
	input wire logic                 cpu_bus_clk,
	input wire logic                 cpu_halt,
	input wire logic                 periph_clk_en,
	input wire logic                 sub_periph_clk_en,
	input wire scm_pkg::scm_osc_en_t osc_en,
	input wire logic                 osc_stop_irq
);
	logic       main_d_reg, main_d_next;
	logic [8:0] quiet_reg, quiet_next;

	// Counts cycles since the raw main oscillator pin last changed.
	always_comb begin
		main_d_next = main_osc_input;
		quiet_next = quiet_reg;
		if (main_d_reg != main_osc_input)
			quiet_next = 9'h000;
		else if (quiet_reg != 9'h1FF)
			quiet_next = quiet_reg + 9'h001;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_d_reg <= 1'b0;
			quiet_reg <= 9'h000;
		end else begin
			main_d_reg <= main_d_next;
			quiet_reg <= quiet_next;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_IRQ_ONE: assert property ($rose(osc_stop_irq) |=> !osc_stop_irq)
		else $error("stop interrupt longer than one cycle");
	AST_IRQ_CAUSE: assert property ($rose(osc_stop_irq) |-> quiet_reg >= 9'd120 || cpu_halt)
		else $error("stop interrupt while main clock still toggling");
	AST_WAIT_ENTER: assert property (clk_en && wait_req && !wake_req && !cpu_halt |=> cpu_halt)
		else $error("wait request did not halt the cpu");
	AST_WAIT_OSC: assert property (clk_en && wait_req && !cpu_halt |=> osc_en.main_en == $past(osc_en.main_en))
		else $error("main oscillator enable changed on wait entry");
	AST_HALT_LOW: assert property (cpu_halt && !cpu_bus_clk |=> !cpu_bus_clk || !cpu_halt)
		else $error("bus clock toggled while halted");
	AST_WAKE: assert property (clk_en && wake_req && cpu_halt |-> ##[1:4] !cpu_halt)
		else $error("wake request did not resume the cpu");
	AST_STOP_ALL: assert property (osc_en == '0 |-> !periph_clk_en && !sub_periph_clk_en)
		else $error("peripheral clock on with all oscillators off");
	AST_RST_DEFAULT: assert property ($rose(hresetn) |-> osc_en.main_en && !osc_en.sub_en && !cpu_halt && !osc_stop_irq)
		else $error("outputs not at reset values after release");

	cover property ($rose(osc_stop_irq));
	cover property ($rose(cpu_halt) && osc_en.main_en);
	cover property (osc_en == '0);
endmodule
`default_nettype wire

/* testbench/scm_clock_ctrl_bench.sv */
// Self-checking bench for the clock controller, bus mastered over AHB-Lite.
// Assumes the package and design under src/ are compiled first.
`timescale 1ns/10ps
`default_nettype none
module scm_clock_ctrl_bench;
	logic                 hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]          haddr, hwdata, hrdata, rd;
	logic [1:0]           htrans;
	logic [2:0]           hsize;
	logic                 main_osc_input, sub_osc_input, ring_osc_input, wait_req, wake_req;
	logic                 cpu_bus_clk, cpu_halt, periph_clk_en, sub_periph_clk_en, osc_stop_irq;
	scm_pkg::scm_osc_en_t osc_en;
	logic                 main_ok;
	int                   error_cnt, checks, oc, p, i;
	// Rows: control 0, control 1, expected bus clock period in hclk cycles.
	logic [7:0]           rows [6][3] = '{'{8'h40, 8'h00, 8'h40}, '{8'h00, 8'h40, 8'h10},
		'{8'h00, 8'h80, 8'h20}, '{8'h00, 8'hC0, 8'h80}, '{8'h40, 8'h80, 8'h40},
		'{8'h00, 8'h00, 8'h08}};

	assign hready = hreadyout;

	scm_clock_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.main_osc_input(main_osc_input), .sub_osc_input(sub_osc_input),
		.ring_osc_input(ring_osc_input), .wait_req(wait_req), .wake_req(wake_req),
		.cpu_bus_clk(cpu_bus_clk), .cpu_halt(cpu_halt), .periph_clk_en(periph_clk_en),
		.sub_periph_clk_en(sub_periph_clk_en), .osc_en(osc_en), .osc_stop_irq(osc_stop_irq));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// Oscillators run only while enabled: main period 8, sub 32, ring 12 hclk cycles.
	always @(posedge hclk) begin
		oc <= oc + 1;
		if (oc % 4 == 3 && osc_en.main_en === 1'b1 && main_ok)
			main_osc_input <= ~main_osc_input;
		if (oc % 16 == 15 && osc_en.sub_en === 1'b1)
			sub_osc_input <= ~sub_osc_input;
		if (oc % 6 == 5 && osc_en.ring_en === 1'b1)
			ring_osc_input <= ~ring_osc_input;
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask

	// Second of two rise-to-rise periods, so a pending ratio change has landed.
	task automatic mchk(input logic [31:0] exp);
		int k, t0, n;
		logic pv;
		for (n = 0; n < 2; n++) begin
			t0 = -1;
			p = 0;
			pv = cpu_bus_clk;
			for (k = 0; k < 600 && p == 0; k++) begin
				@(posedge hclk);
				if (cpu_bus_clk === 1'b1 && pv === 1'b0) begin
					if (t0 >= 0)
						p = k - t0;
					t0 = k;
				end
				pv = cpu_bus_clk;
			end
		end
		chk(32'(p), exp);
	endtask

	task automatic pulse_wait(input logic wake);
		@(posedge hclk);
		if (wake) wake_req <= 1'b1; else wait_req <= 1'b1;
		@(posedge hclk);
		wake_req <= 1'b0;
		wait_req <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask

	task automatic stop_test;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#400000;
		error_cnt++;
		stop_test;
	end

	initial begin
		hresetn = 1'b0; clk_en = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00;
		hwrite = 1'b0; hsize = 3'h2; hwdata = '0; wait_req = 1'b0; wake_req = 1'b0;
		main_osc_input = 1'b0; sub_osc_input = 1'b0; ring_osc_input = 1'b0;
		main_ok = 1'b1; error_cnt = 0; checks = 0; oc = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(8'h18, 32'h40);
		rdc(8'h30, 32'h00);
		bus(1'b1, 8'h18, 32'h00);
		rdc(8'h18, 32'h40);
		bus(1'b1, 8'h28, 32'h01);
		for (i = 0; i < 6; i++) begin
			bus(1'b1, 8'h1C, {24'h000000, rows[i][1]});
			bus(1'b1, 8'h18, {24'h000000, rows[i][0]});
			mchk({24'h000000, rows[i][2]});
		end
		rdc(8'h28, 32'h01);
		bus(1'b1, 8'h04, 32'hFFFFFFFF);
		rdc(8'h04, 32'h00);
		// Low-speed and low power dissipation modes.
		bus(1'b1, 8'h18, 32'h40);
		bus(1'b1, 8'h18, 32'h50);
		repeat (100) @(posedge hclk);
		bus(1'b1, 8'h18, 32'hD0);
		mchk(32'd32);
		bus(1'b1, 8'h18, 32'hF0);
		repeat (4) @(posedge hclk);
		chk({29'h0, osc_en.main_en, periph_clk_en, sub_periph_clk_en}, 32'h1);
		mchk(32'd32);
		bus(1'b1, 8'h18, 32'hD0);
		repeat (100) @(posedge hclk);
		// Leave the sub clock while it still runs, then stop it.
		bus(1'b1, 8'h18, 32'h50);
		mchk(32'd64);
		bus(1'b1, 8'h18, 32'h40);
		// Ring oscillator mode, entered and left through divide by 8.
		bus(1'b1, 8'h1C, 32'h10);
		rdc(8'h1C, 32'h10);
		bus(1'b1, 8'h30, 32'h04);
		rdc(8'h1C, 32'h00);
		mchk(32'd96);
		bus(1'b1, 8'h18, 32'h60);
		repeat (4) @(posedge hclk);
		chk({31'h0, osc_en.main_en}, 32'h0);
		mchk(32'd96);
		bus(1'b1, 8'h18, 32'h40);
		repeat (60) @(posedge hclk);
		bus(1'b1, 8'h30, 32'h00);
		mchk(32'd64);
		// Wait mode, then stop mode from divide by 2.
		pulse_wait(1'b0);
		repeat (40) @(posedge hclk);
		chk({30'h0, cpu_halt, osc_en.main_en}, 32'h3);
		chk({31'h0, cpu_bus_clk}, 32'h0);
		pulse_wait(1'b1);
		chk({31'h0, cpu_halt}, 32'h0);
		bus(1'b1, 8'h1C, 32'h40);
		bus(1'b1, 8'h18, 32'h00);
		bus(1'b1, 8'h1C, 32'h41);
		repeat (4) @(posedge hclk);
		chk({26'h0, cpu_halt, osc_en, periph_clk_en, sub_periph_clk_en}, 32'h20);
		pulse_wait(1'b1);
		rdc(8'h18, 32'h40);
		// Detection off unless both enables are set.
		bus(1'b1, 8'h30, 32'h01);
		main_ok <= 1'b0;
		for (i = 0; i < 300 && osc_stop_irq !== 1'b1; i++) @(posedge hclk);
		chk(32'(i), 32'd300);
		rdc(8'h30, 32'h01);
		main_ok <= 1'b1;
		repeat (20) @(posedge hclk);
		bus(1'b1, 8'h30, 32'h03);
		main_ok <= 1'b0;
		for (i = 0; i < 300 && osc_stop_irq !== 1'b1; i++) @(posedge hclk);
		chk({31'h0, i >= 120 && i < 140}, 32'h1);
		rdc(8'h30, 32'h0F);
		mchk(32'd96);
		main_ok <= 1'b1;
		repeat (20) @(posedge hclk);
		bus(1'b1, 8'h30, 32'h04);
		bus(1'b1, 8'h30, 32'h00);
		rdc(8'h30, 32'h00);
		// Wait with peripheral clocks stopped counts as an oscillator stop.
		bus(1'b1, 8'h18, 32'h44);
		bus(1'b1, 8'h30, 32'h03);
		@(posedge hclk);
		wait_req <= 1'b1;
		@(posedge hclk);
		wait_req <= 1'b0;
		for (i = 0; i < 20 && osc_stop_irq !== 1'b1; i++) @(posedge hclk);
		chk({31'h0, i < 20}, 32'h1);
		pulse_wait(1'b1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(8'h18, 32'h40);
		rdc(8'h28, 32'h00);
		stop_test;
	end
endmodule

bind scm_clock_ctrl scm_clock_ctrl_assertions i_chk (.hclk(hclk), .hresetn(hresetn),
	.clk_en(clk_en), .main_osc_input(main_osc_input), .wait_req(wait_req),
	.wake_req(wake_req), .cpu_bus_clk(cpu_bus_clk), .cpu_halt(cpu_halt),
	.periph_clk_en(periph_clk_en), .sub_periph_clk_en(sub_periph_clk_en),
	.osc_en(osc_en), .osc_stop_irq(osc_stop_irq));
`default_nettype wire
